// >>> rtl/ddc_link_defines.vh
`ifndef DDC_LINK_DEFINES_VH
`define DDC_LINK_DEFINES_VH

// APB register byte addresses
`define ADDR_CTRL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_WORDS 12'h008

// Control register fields
`define CTRL_MODE_LO 0
`define CTRL_MODE_HI 2
`define CTRL_BOOST 3
`define CTRL_ENC64 4
`define CTRL_FEC 5
`define CTRL_ENABLE 6
`define CTRL_LANES_LO 8
`define CTRL_LANES_HI 11
`define CTRL_K_LO 16
`define CTRL_K_HI 23
`define CTRL_WMASK 32'h00ff0f7f
`define CTRL_RESET 32'h001f0000

// Link mode select codes
`define MODE_BYPASS 3'h0
`define MODE_DEC4 3'h1
`define MODE_DEC8 3'h2
`define MODE_DEC16 3'h3
`define MODE_DEC32 3'h4

// Log2 of decimation factors
`define SH_1 3'h0
`define SH_4 3'h2
`define SH_8 3'h3
`define SH_16 3'h4
`define SH_32 3'h5

// Link states
`define ST_OFF 3'h0
`define ST_CGS 3'h1
`define ST_WAIT 3'h2
`define ST_ILAS 3'h3
`define ST_DATA 3'h4

// Control characters and sync headers
`define K28_5 8'hbc
`define K28_0 8'h1c
`define K28_3 8'h7c
`define ILAS_MF_LAST 2'h3
`define BLK_LAST 2'h3
`define HDR_DATA 2'h1
`define HDR_NONE 2'h0

// Saturation limits for 15-bit results
`define SAT_MAX 15'h3fff
`define SAT_MIN 15'h4000

`endif

// >>> rtl/ddc_output_serial_link_tx.v
`include "ddc_link_defines.vh"

module ddc_output_serial_link_tx (
  input wire CLOCK,
  input wire RST_N,
  input wire CE,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire IN_VALID,
  input wire [14:0] IN_I,
  input wire [14:0] IN_Q,
  input wire IN_OVR_FIRST,
  input wire IN_OVR_SECOND,
  input wire SYNC_N,
  input wire SYSREF,
  output reg [15:0] TX_WORD,
  output reg [1:0] TX_CTRL_K,
  output reg TX_SAMPLE_VALID,
  output reg [1:0] TX_HDR,
  output reg TX_ENC64,
  output reg TX_FEC_EN,
  output reg [15:0] TX_LANE_EN,
  output reg NCO_SYNC
);

  ////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Log2 of the decimation factor for a mode code
  function [2:0] dec_shift;
    input [2:0] mode;
    begin
      case (mode)
        `MODE_DEC4: dec_shift = `SH_4;
        `MODE_DEC8: dec_shift = `SH_8;
        `MODE_DEC16: dec_shift = `SH_16;
        `MODE_DEC32: dec_shift = `SH_32;
        default: dec_shift = `SH_1;
      endcase
    end
  endfunction

  // Clamp a wide signed value into 15 bits
  function [14:0] sat15;
    input [21:0] v;
    begin
      if (!v[21] && (v[20:14] != 7'h00)) begin
        sat15 = `SAT_MAX;
      end else if (v[21] && (v[20:14] != 7'h7f)) begin
        sat15 = `SAT_MIN;
      end else begin
        sat15 = v[14:0];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers and state

  reg [31:0] ctrl_ff;
  reg [31:0] words_ff;
  reg [2:0] state_ff;
  reg [7:0] lmfc_ff;
  reg [1:0] ilas_mf_ff;
  reg [1:0] blk_ff;
  reg sync_prev_ff;
  reg sysref_prev_ff;
  reg [4:0] cnt_ff;
  reg signed [19:0] acc_i_ff;
  reg signed [19:0] acc_q_ff;
  reg ovr0_ff;
  reg ovr1_ff;
  reg pend_ff;
  reg [15:0] pend_word_ff;
  reg have_ff;
  reg [15:0] word_ff;

  wire [2:0] mode = ctrl_ff[`CTRL_MODE_HI:`CTRL_MODE_LO];
  wire boost = ctrl_ff[`CTRL_BOOST];
  wire enc64 = ctrl_ff[`CTRL_ENC64];
  wire enable = ctrl_ff[`CTRL_ENABLE];
  wire [3:0] lanes_m1 = ctrl_ff[`CTRL_LANES_HI:`CTRL_LANES_LO];
  wire [7:0] k_m1 = ctrl_ff[`CTRL_K_HI:`CTRL_K_LO];
  wire [2:0] sh = dec_shift(mode);
  wire bypass = (sh == `SH_1);
  wire [4:0] cnt_last = (5'h01 << sh) - 5'h01;
  wire lmfc_wrap = (lmfc_ff == k_m1);
  wire sync_rise = SYNC_N && !sync_prev_ff;
  wire sync_fall = !SYNC_N && sync_prev_ff;
  wire sysref_rise = SYSREF && !sysref_prev_ff;
  wire apb_req = PSEL && PENABLE && !PREADY;
  wire apb_done = PSEL && PENABLE && PREADY;
  wire hit_ctrl = (PADDR == `ADDR_CTRL);
  wire hit_stat = (PADDR == `ADDR_STATUS);
  wire hit_words = (PADDR == `ADDR_WORDS);

  ////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, write lands on the completing edge

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_ff <= `CTRL_RESET;
      PREADY <= 1'b0;
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      PREADY <= apb_req;
      PSLVERR <= apb_req && !(hit_ctrl || hit_stat || hit_words);
      if (apb_req && !PWRITE) begin
        if (hit_ctrl) begin
          PRDATA <= ctrl_ff;
        end else if (hit_stat) begin
          PRDATA <= {15'h0000, !SYNC_N, lmfc_ff, 5'h00, state_ff};
        end else if (hit_words) begin
          PRDATA <= words_ff;
        end else begin
          PRDATA <= 32'h00000000;
        end
      end
      if (apb_done && PWRITE && hit_ctrl) begin
        ctrl_ff <= PWDATA & `CTRL_WMASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Edge history of SYNC and SYSREF

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sync_prev_ff <= 1'b1;
      sysref_prev_ff <= 1'b0;
    end else if (CE) begin
      sync_prev_ff <= SYNC_N;
      sysref_prev_ff <= SYSREF;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Multiframe / extended multiblock counter and 64B/66B block counter

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      lmfc_ff <= 8'h00;
      blk_ff <= 2'h0;
    end else if (CE) begin
      if (sysref_rise) begin
        lmfc_ff <= 8'h00;
        blk_ff <= 2'h0;
      end else begin
        lmfc_ff <= lmfc_wrap ? 8'h00 : lmfc_ff + 8'h01;
        blk_ff <= blk_ff + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link state machine, shared by all lanes so they stay aligned

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= `ST_OFF;
      ilas_mf_ff <= 2'h0;
    end else if (CE) begin
      if (!enable) begin
        state_ff <= `ST_OFF;
      end else if (enc64) begin
        state_ff <= `ST_DATA;
      end else begin
        case (state_ff)
          `ST_OFF: begin
            state_ff <= `ST_CGS;
          end
          `ST_CGS: begin
            if (sync_rise) begin
              state_ff <= `ST_WAIT;
            end
          end
          `ST_WAIT: begin
            if (!SYNC_N) begin
              state_ff <= `ST_CGS;
            end else if (lmfc_wrap) begin
              state_ff <= `ST_ILAS;
              ilas_mf_ff <= 2'h0;
            end
          end
          `ST_ILAS: begin
            if (!SYNC_N) begin
              state_ff <= `ST_CGS;
            end else if (lmfc_wrap) begin
              ilas_mf_ff <= ilas_mf_ff + 2'h1;
              if (ilas_mf_ff == `ILAS_MF_LAST) begin
                state_ff <= `ST_DATA;
              end
            end
          end
          `ST_DATA: begin
            if (!SYNC_N) begin
              state_ff <= `ST_CGS;
            end
          end
          default: begin
            state_ff <= `ST_OFF;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decimation by accumulate and dump with gain select

  wire signed [19:0] sum_i = acc_i_ff + {{5{IN_I[14]}}, IN_I};
  wire signed [19:0] sum_q = acc_q_ff + {{5{IN_Q[14]}}, IN_Q};
  wire [2:0] net_sh = sh - {2'h0, boost};
  wire signed [21:0] scl_i = $signed({{2{sum_i[19]}}, sum_i}) >>> net_sh;
  wire signed [21:0] scl_q = $signed({{2{sum_q[19]}}, sum_q}) >>> net_sh;
  wire ovr0_win = ovr0_ff || IN_OVR_FIRST;
  wire ovr1_win = ovr1_ff || IN_OVR_SECOND;

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_ff <= 5'h00;
      acc_i_ff <= 20'h00000;
      acc_q_ff <= 20'h00000;
      ovr0_ff <= 1'b0;
      ovr1_ff <= 1'b0;
      have_ff <= 1'b0;
      word_ff <= 16'h0000;
      pend_ff <= 1'b0;
      pend_word_ff <= 16'h0000;
    end else if (CE) begin
      have_ff <= 1'b0;
      if (pend_ff) begin
        have_ff <= 1'b1;
        word_ff <= pend_word_ff;
        pend_ff <= 1'b0;
      end
      if (IN_VALID && bypass) begin
        have_ff <= 1'b1;
        word_ff <= {IN_I, IN_OVR_FIRST};
      end else if (IN_VALID && (cnt_ff == cnt_last)) begin
        cnt_ff <= 5'h00;
        acc_i_ff <= 20'h00000;
        acc_q_ff <= 20'h00000;
        ovr0_ff <= 1'b0;
        ovr1_ff <= 1'b0;
        have_ff <= 1'b1;
        word_ff <= {sat15(scl_i), ovr0_win};
        pend_ff <= 1'b1;
        pend_word_ff <= {sat15(scl_q), ovr1_win};
      end else if (IN_VALID) begin
        cnt_ff <= cnt_ff + 5'h01;
        acc_i_ff <= sum_i;
        acc_q_ff <= sum_q;
        ovr0_ff <= ovr0_win;
        ovr1_ff <= ovr1_win;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Lane word mux: commas, alignment sequence or sample words

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      TX_WORD <= 16'h0000;
      TX_CTRL_K <= 2'h0;
      TX_SAMPLE_VALID <= 1'b0;
      TX_HDR <= `HDR_NONE;
      words_ff <= 32'h00000000;
    end else if (CE) begin
      TX_SAMPLE_VALID <= 1'b0;
      TX_HDR <= `HDR_NONE;
      TX_CTRL_K <= 2'h0;
      case (state_ff)
        `ST_CGS, `ST_WAIT: begin
          TX_WORD <= {`K28_5, `K28_5};
          TX_CTRL_K <= 2'h3;
        end
        `ST_ILAS: begin
          if (lmfc_ff == 8'h00) begin
            TX_WORD <= {`K28_0, lmfc_ff};
            TX_CTRL_K <= 2'h2;
          end else if (lmfc_wrap) begin
            TX_WORD <= {lmfc_ff, `K28_3};
            TX_CTRL_K <= 2'h1;
          end else begin
            TX_WORD <= {lmfc_ff, lmfc_ff};
          end
        end
        `ST_DATA: begin
          TX_WORD <= have_ff ? word_ff : 16'h0000;
          TX_SAMPLE_VALID <= have_ff;
          if (have_ff) begin
            words_ff <= words_ff + 32'h00000001;
          end
          if (enc64 && (blk_ff == 2'h0)) begin
            TX_HDR <= `HDR_DATA;
          end
        end
        default: begin
          TX_WORD <= 16'h0000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Coding, correction and oscillator-sync outputs

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      TX_ENC64 <= 1'b0;
      TX_FEC_EN <= 1'b0;
      NCO_SYNC <= 1'b0;
    end else if (CE) begin
      TX_ENC64 <= enc64;
      TX_FEC_EN <= enc64 && ctrl_ff[`CTRL_FEC];
      NCO_SYNC <= enable && enc64 && sync_fall;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Lane enables from the configured lane count

  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : lane
      always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
          TX_LANE_EN[g] <= 1'b0;
        end else if (CE) begin
          TX_LANE_EN[g] <= enable && (g <= lanes_m1);
        end
      end
    end
  endgenerate

endmodule

// >>> tb/ddc_link_checker.sv
module ddc_link_checker (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [11:0] PADDR,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic SYNC_N,
  input wire logic [15:0] TX_WORD,
  input wire logic [1:0] TX_CTRL_K,
  input wire logic TX_SAMPLE_VALID,
  input wire logic [1:0] TX_HDR,
  input wire logic TX_ENC64,
  input wire logic TX_FEC_EN,
  input wire logic [15:0] TX_LANE_EN,
  input wire logic NCO_SYNC
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////
  // Register bus answers after one wait state, errors off the map
  apb_wait_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("bus answer late");
  apb_err_a: assert property (PREADY |-> PSLVERR == !(PADDR == 12'h000 || PADDR == 12'h004 || PADDR == 12'h008))
    else $error("bus error flag wrong");
  // Link framing on the lane word, block coding, correction and oscillator sync
  comma_cgs_a: assert property ((!SYNC_N && TX_LANE_EN[0] && !TX_ENC64) [*4]
    |-> TX_WORD == 16'hbcbc && TX_CTRL_K == 2'b11) else $error("comma missing");
  ilas_wait_a: assert property ($rose(SYNC_N) && !TX_ENC64 |=> TX_CTRL_K != 2'b10)
    else $error("alignment started early");
  data_only_a: assert property (TX_SAMPLE_VALID |-> TX_CTRL_K == 2'b00)
    else $error("sample word marked control");
  hdr_mode_a: assert property (TX_HDR != 2'b00 |-> TX_ENC64 && TX_HDR == 2'b01)
    else $error("header in wrong mode");
  hdr_period_a: assert property (TX_HDR == 2'b01 |=> (TX_HDR == 2'b00) [*3] ##1 TX_HDR == 2'b01)
    else $error("header spacing wrong");
  fec_mode_a: assert property (TX_FEC_EN |-> TX_ENC64)
    else $error("fec without block coding");
  nco_fall_a: assert property ($fell(SYNC_N) && TX_ENC64 && TX_LANE_EN[0] |-> ##[1:2] NCO_SYNC)
    else $error("oscillator sync missing");
  nco_mode_a: assert property (NCO_SYNC |-> TX_ENC64)
    else $error("oscillator sync in wrong mode");
  // Main scenarios reached
  cover property (TX_SAMPLE_VALID);
  cover property (TX_CTRL_K == 2'b01);
  cover property (NCO_SYNC);
  cover property (PSLVERR);
endmodule

bind ddc_output_serial_link_tx ddc_link_checker chk_u (.CLOCK, .RST_N, .PSEL, .PENABLE, .PADDR,
  .PREADY, .PSLVERR, .SYNC_N, .TX_WORD, .TX_CTRL_K, .TX_SAMPLE_VALID, .TX_HDR, .TX_ENC64,
  .TX_FEC_EN, .TX_LANE_EN, .NCO_SYNC);

// >>> tb/ddc_link_rx_model.sv
module ddc_link_rx_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic [15:0] word,
  input wire logic [1:0] ctrl_k,
  input wire logic [1:0] hdr,
  output logic sync_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic low_ff;
  logic [2:0] cnt_ff;
  // Holds the link request until four comma words or a block header arrive
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_ff <= 1'b0;
      cnt_ff <= 3'h0;
    end else if (req) begin
      low_ff <= 1'b1;
      cnt_ff <= 3'h0;
    end else if (low_ff && (hdr != 2'h0 || cnt_ff == 3'h4)) begin
      low_ff <= 1'b0;
    end else if (low_ff && word == 16'hbcbc && ctrl_k == 2'b11) begin
      cnt_ff <= cnt_ff + 3'h1;
    end else begin
      cnt_ff <= 3'h0;
    end
  end
  assign sync_n = !low_ff;
endmodule

// >>> tb/ddc_output_serial_link_tx_test.sv
module ddc_output_serial_link_tx_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLOCK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, IN_VALID = 0;
  logic IN_OVR_FIRST = 0, IN_OVR_SECOND = 0, SYSREF = 0, req = 0, er, CE = 1;
  logic [11:0] PADDR = 0;
  logic [31:0] PWDATA = 0, rd;
  logic [14:0] IN_I = 0, IN_Q = 0;
  wire [31:0] PRDATA;
  wire [15:0] TX_WORD, TX_LANE_EN;
  wire [1:0] TX_CTRL_K, TX_HDR;
  wire PREADY, PSLVERR, TX_SAMPLE_VALID, TX_ENC64, TX_FEC_EN, NCO_SYNC, SYNC_N;
  int error_cnt = 0, n_compared = 0, r_cnt = 0, nco_cnt = 0;
  ////////////////////////////////////////////////////////////////
  ddc_output_serial_link_tx dut_u (.CLOCK, .RST_N, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PRDATA, .PREADY, .PSLVERR, .IN_VALID, .IN_I, .IN_Q, .IN_OVR_FIRST, .IN_OVR_SECOND,
    .SYNC_N, .SYSREF, .TX_WORD, .TX_CTRL_K, .TX_SAMPLE_VALID, .TX_HDR, .TX_ENC64, .TX_FEC_EN,
    .TX_LANE_EN, .NCO_SYNC);
  ddc_link_rx_model rx_u (.clk(CLOCK), .rst_n(RST_N), .req(req), .word(TX_WORD),
    .ctrl_k(TX_CTRL_K), .hdr(TX_HDR), .sync_n(SYNC_N));
  // 20 MHz device clock
  always #25 CLOCK = ~CLOCK;
  // Tallies alignment-start characters and oscillator sync pulses
  always @(posedge CLOCK) begin
    if (TX_CTRL_K == 2'b10) r_cnt <= r_cnt + 1;
    if (NCO_SYNC === 1'b1) nco_cnt <= nco_cnt + 1;
  end
  ////////////////////////////////////////////////////////////////
  task end_of_test;
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus transfer: setup, access, held until ready is sampled
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge CLOCK);
    PSEL <= 1;
    PENABLE <= 0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1;
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
    if (n >= 20) begin
      error_cnt++;
      end_of_test;
    end
  endtask
  // Requests the link and polls status until the data state
  task link_up;
    int n;
    @(posedge CLOCK);
    req <= 1;
    @(posedge CLOCK);
    req <= 0;
    n = 0;
    do begin
      apb(0, 12'h004, 0);
      n++;
    end while (rd[2:0] !== 3'h4 && n < 100);
    if (n >= 100) begin
      error_cnt++;
      end_of_test;
    end
  endtask
  // Feeds one output window and checks the I word, and the Q word when decimating
  task dec(input logic [2:0] m, input logic b, input logic [14:0] a, ei, eq);
    int n;
    n = (m == 0) ? 1 : 2 << m;
    apb(1, 12'h000, 32'h00030340 | m | (b << 3));
    for (int k = 0; k < n; k++) begin
      @(posedge CLOCK);
      IN_VALID <= 1;
      IN_I <= a;
      IN_Q <= -a;
      IN_OVR_FIRST <= !b && k == n - 1;
      IN_OVR_SECOND <= b && k == 0;
    end
    @(posedge CLOCK);
    IN_VALID <= 0;
    IN_OVR_FIRST <= 0;
    IN_OVR_SECOND <= 0;
    n = 0;
    while (TX_SAMPLE_VALID !== 1'b1 && n < 20) begin
      @(posedge CLOCK);
      n++;
    end
    chk(TX_SAMPLE_VALID, 1);
    chk(TX_WORD, {ei, !b});
    if (m != 0) begin
      @(posedge CLOCK);
      chk(TX_WORD, {eq, b});
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(posedge CLOCK);
    RST_N <= 1;
    apb(0, 12'h000, 0);
    chk(rd, 32'h001f0000);
    apb(0, 12'h00c, 0);
    chk(er, 1);
    chk(rd, 0);
    apb(1, 12'h000, 32'h00030300);
    @(posedge CLOCK);
    IN_VALID <= 1;
    SYSREF <= 1;
    @(posedge CLOCK);
    IN_VALID <= 0;
    SYSREF <= 0;
    // Counter restarted by the reference, read back with one wait state
    apb(0, 12'h004, 0);
    chk(rd, 32'h00000200);
    apb(1, 12'h000, 32'h00030340);
    link_up;
    chk(r_cnt, 4);
    chk(TX_LANE_EN, 16'h000f);
    dec(0, 0, 15'h1234, 15'h1234, 15'h0);
    // A sample offered while the clock enable is low is lost
    @(posedge CLOCK);
    CE <= 0;
    IN_VALID <= 1;
    @(posedge CLOCK);
    IN_VALID <= 0;
    @(posedge CLOCK);
    CE <= 1;
    for (int m = 1; m < 5; m++) begin
      for (int b = 0; b < 2; b++) dec(m, b, 15'h0300, 15'h0300 << b, -(15'h0300 << b));
    end
    dec(1, 1, 15'h3000, 15'h3fff, 15'h4000);
    apb(1, 12'h000, 32'h00030f70);
    link_up;
    apb(0, 12'h008, 0);
    chk(rd, 19);
    chk(TX_ENC64, 1);
    chk(TX_FEC_EN, 1);
    chk(TX_LANE_EN, 16'hffff);
    chk(nco_cnt, 1);
    end_of_test;
  end
endmodule
